/* core/scp_fifo.sv */
// Purpose: payload buffer between receiver and serial readout
// Assumes: both sides on clk; DEPTH a power of two
// Notes:   full and empty come from an explicit occupancy count
`timescale 1ns/1ps
module scp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != DEPTH[PW:0]);
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

/* core/scp_pkg.sv */
// Purpose: shared constants and types of the serial control port
// Assumes: one 40 MHz system clock, serial pins sampled into it
// Notes:   local register offsets; the rest of the map is plain storage
package scp_pkg;

  // instruction codes, first byte of every frame
  localparam logic [7:0] CMD_WRITE       = 8'h02;
  localparam logic [7:0] CMD_READ        = 8'h03;
  localparam logic [7:0] CMD_FIFO_READ   = 8'h04;
  localparam logic [7:0] CMD_BURST_WRITE = 8'h01;
  localparam logic [7:0] CMD_BURST_READ  = 8'h05;

  // register offsets inside the port
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_ADDRESS_TRACE = 8'h01;
  localparam logic [7:0] ADDR_DATA_TRACE    = 8'h02;
  localparam logic [7:0] ADDR_CHECKSUM      = 8'h03;
  localparam logic [7:0] ADDR_SERIAL_BYTE0  = 8'h04;
  localparam logic [7:0] ADDR_SERIAL_BYTE1  = 8'h05;
  localparam logic [7:0] ADDR_SERIAL_BYTE2  = 8'h06;
  localparam logic [7:0] ADDR_SERIAL_BYTE3  = 8'h07;
  localparam logic [7:0] ADDR_CFG_BASE      = 8'h08;

  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_BITS  = 3'h0;
  // value is arbitrary; bit 6 set and bit 5 clear in byte 0
  localparam logic [31:0] SERIAL_NUMBER = 32'h5a3c_9e40;

  // structure widths
  localparam int BYTE_W     = 8;
  localparam int REG_COUNT  = 256;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] BITS_PER_WORD = 8'h08;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } scp_cfg_wr_t;

  typedef enum logic [6:0] {
    ST_CMD    = 7'b000_0001,
    ST_ADDR   = 7'b000_0010,
    ST_WRITE  = 7'b000_0100,
    ST_READ   = 7'b000_1000,
    ST_FIFO   = 7'b001_0000,
    ST_STATUS = 7'b010_0000,
    ST_IGNORE = 7'b100_0000
  } scp_state_t;

endpackage

/* core/scp_spi_slave.sv */
// Purpose: four-wire serial slave port for register and payload access
// Assumes: mode 0 master, serial clock well below clk / 4
// Notes:   pins are oversampled; edges found after a two-stage synchroniser
// How it works
// [R1] burst read streams from start address
// [R2] master avoids ending burst below clear-on-read
// [R3] single write: instruction, address, one data
// [R4] writes copy address and data into traces
// [R5] traces always hold the latest write
// [R6] burst write stores at incrementing addresses
// [R7] burst write traces follow each byte
// [R8] checksum XORs address and data bytes
// [R9] reading checksum clears it
// [R10] burst checksum covers start address and data
// [R11] fifo read: payload then valid-bit count
// [R12] decode both write instruction codes
// [R13] decode three read instruction codes
// [R14] fixed 32-bit serial number in four bytes
// [R15] sample on rising, drive on falling edge
// [R16] MSB first except fifo payload bits
// [R17] new instruction after each completed frame
// [R18] clear-on-read captured early, cleared after byte
// [R19] burst read increments address per byte
// [R20] output released and frame aborted on deselect
`timescale 1ns/1ps
module scp_spi_slave (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // serial pins
  input  wire logic                spiClk,
  input  wire logic                chip_select_n,
  input  wire logic                spiDataIn,
  output logic                     spiDataOut,
  output logic                     spiDataOutEn,
  // payload from the receiver
  input  wire logic                rxWordValid,
  output logic                     rxWordReady,
  input  wire logic [7:0]          rxWordData,
  // clear-on-read status owned elsewhere
  input  wire logic [7:0]          irqStatus,
  output logic                     irqStatusClear,
  // configuration writes toward the receiver
  output logic                     cfgWrValid,
  output scp_pkg::scp_cfg_wr_t     cfgWr
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic [2:0] clkSync_r;
  logic [1:0] csSync_r;
  logic [1:0] dinSync_r;
  logic       csHigh_r;
  logic       sclkRise;
  logic       sclkFall;
  logic       csRise;
  logic       selected;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkSync_r <= 3'h0;
      csSync_r  <= 2'h3;
      dinSync_r <= 2'h0;
      csHigh_r  <= 1'b1;
    end else begin
      clkSync_r <= {clkSync_r[1:0], spiClk};
      csSync_r  <= {csSync_r[0], chip_select_n};
      dinSync_r <= {dinSync_r[0], spiDataIn};
      csHigh_r  <= csSync_r[1];
    end
  end

  assign selected = !csSync_r[1];
  assign sclkRise = selected && clkSync_r[1] && !clkSync_r[2]; // R15
  assign sclkFall = selected && !clkSync_r[1] && clkSync_r[2]; // R15
  assign csRise   = csSync_r[1] && !csHigh_r;

  ////////////////////////////////////////////////////////////////////////
  // frame state

  scp_pkg::scp_state_t state_r;
  logic [2:0]          bitCnt_r;
  logic [6:0]          rxShift_r;
  logic [7:0]          rxByte;
  logic                byteDone;
  logic                burst_r;
  logic                isWrite_r;
  logic [7:0]          addr_r;
  logic [7:0]          tx_r;
  logic                lsbFirst_r;
  logic [7:0]          fifoBits_r;
  logic [7:0]          addrTrace_r;
  logic [7:0]          dataTrace_r;
  logic [7:0]          checksum_r;
  logic                clearIsPend_r;
  logic [7:0]          cfgMem [scp_pkg::REG_COUNT];
  logic                fifoOutValid;
  logic [7:0]          fifoOutData;
  logic                fifoPop;
  logic                wrStrobe;
  logic                chkClear;
  logic [7:0]          nextAddr;

  assign rxByte   = {rxShift_r, dinSync_r[1]};
  assign byteDone = sclkRise && (bitCnt_r == 3'h7);
  assign wrStrobe = byteDone && (state_r == scp_pkg::ST_WRITE);
  assign chkClear = byteDone && (state_r == scp_pkg::ST_READ)
                    && (addr_r == scp_pkg::ADDR_CHECKSUM);
  assign nextAddr = addr_r + 8'h01;
  // pop only when the word is loaded into the shifter
  assign fifoPop  = byteDone && fifoOutValid && ((state_r == scp_pkg::ST_FIFO)
                    || ((state_r == scp_pkg::ST_CMD)
                    && (rxByte == scp_pkg::CMD_FIFO_READ)));

  // register view seen by the master
  function automatic logic [7:0] regRead(input logic [7:0] a);
    case (a)
      scp_pkg::ADDR_IRQ_STATUS:    regRead = irqStatus;
      scp_pkg::ADDR_ADDRESS_TRACE: regRead = addrTrace_r; // R4
      scp_pkg::ADDR_DATA_TRACE:    regRead = dataTrace_r; // R4
      scp_pkg::ADDR_CHECKSUM:      regRead = checksum_r;
      scp_pkg::ADDR_SERIAL_BYTE0:  regRead = scp_pkg::SERIAL_NUMBER[7:0];   // R14
      scp_pkg::ADDR_SERIAL_BYTE1:  regRead = scp_pkg::SERIAL_NUMBER[15:8];  // R14
      scp_pkg::ADDR_SERIAL_BYTE2:  regRead = scp_pkg::SERIAL_NUMBER[23:16]; // R14
      scp_pkg::ADDR_SERIAL_BYTE3:  regRead = scp_pkg::SERIAL_NUMBER[31:24]; // R14
      default:                     regRead = cfgMem[a];
    endcase
  endfunction

  // bit counter and receive shifter; deselect aborts any partial byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCnt_r  <= scp_pkg::RST_BITS;
      rxShift_r <= 7'h00;
    end else if (!selected) begin
      bitCnt_r  <= scp_pkg::RST_BITS; // R20
    end else if (sclkRise) begin
      bitCnt_r  <= bitCnt_r + 3'h1;
      rxShift_r <= rxByte[6:0]; // R16
    end
  end

  // instruction decode and sequencing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= scp_pkg::ST_CMD;
      burst_r   <= 1'b0;
      isWrite_r <= 1'b0;
      addr_r    <= scp_pkg::RST_BYTE;
    end else if (!selected) begin
      state_r   <= scp_pkg::ST_CMD; // R20
    end else if (byteDone) begin
      case (state_r)
        scp_pkg::ST_CMD: begin
          case (rxByte)
            scp_pkg::CMD_WRITE, scp_pkg::CMD_BURST_WRITE: begin // R12
              state_r   <= scp_pkg::ST_ADDR;
              isWrite_r <= 1'b1;
              burst_r   <= (rxByte == scp_pkg::CMD_BURST_WRITE);
            end
            scp_pkg::CMD_READ, scp_pkg::CMD_BURST_READ: begin // R13
              state_r   <= scp_pkg::ST_ADDR;
              isWrite_r <= 1'b0;
              burst_r   <= (rxByte == scp_pkg::CMD_BURST_READ);
            end
            scp_pkg::CMD_FIFO_READ: begin // R11 R13
              state_r <= fifoOutValid ? scp_pkg::ST_FIFO : scp_pkg::ST_STATUS;
            end
            default: state_r <= scp_pkg::ST_IGNORE;
          endcase
        end
        scp_pkg::ST_ADDR: begin
          addr_r  <= rxByte;
          state_r <= isWrite_r ? scp_pkg::ST_WRITE : scp_pkg::ST_READ;
        end
        scp_pkg::ST_WRITE: begin
          if (burst_r) begin
            addr_r <= nextAddr; // R6
          end else begin
            state_r <= scp_pkg::ST_CMD; // R3 R17
          end
        end
        scp_pkg::ST_READ: begin
          if (burst_r) begin
            addr_r <= nextAddr; // R1 R19
          end else begin
            state_r <= scp_pkg::ST_CMD; // R17
          end
        end
        scp_pkg::ST_FIFO: begin
          if (!fifoOutValid) begin
            state_r <= scp_pkg::ST_STATUS; // R11
          end
        end
        scp_pkg::ST_STATUS: state_r <= scp_pkg::ST_CMD; // R17
        scp_pkg::ST_IGNORE: state_r <= scp_pkg::ST_IGNORE;
        default:            state_r <= scp_pkg::ST_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit shifter: loaded on the closing rising edge, shifted on falling

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_r       <= scp_pkg::RST_BYTE;
      lsbFirst_r <= 1'b0;
      spiDataOut <= 1'b0;
    end else if (!selected) begin
      tx_r       <= scp_pkg::RST_BYTE;
      lsbFirst_r <= 1'b0;
    end else if (byteDone) begin
      lsbFirst_r <= 1'b0;
      tx_r       <= scp_pkg::RST_BYTE;
      if ((state_r == scp_pkg::ST_ADDR) && !isWrite_r) begin
        tx_r <= regRead(rxByte); // R18
      end else if ((state_r == scp_pkg::ST_READ) && burst_r) begin
        tx_r <= regRead(nextAddr); // R19
      end else if (fifoPop) begin
        tx_r       <= fifoOutData; // R11
        lsbFirst_r <= 1'b1; // R16
      end else if ((state_r == scp_pkg::ST_FIFO)
                   || ((state_r == scp_pkg::ST_CMD)
                   && (rxByte == scp_pkg::CMD_FIFO_READ))) begin
        // count includes the word that just finished
        tx_r <= (state_r == scp_pkg::ST_FIFO) ? fifoBits_r : scp_pkg::RST_BYTE; // R11
      end
    end else if (sclkFall) begin
      spiDataOut <= lsbFirst_r ? tx_r[0] : tx_r[7]; // R15 R16
      tx_r       <= lsbFirst_r ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  assign spiDataOutEn = selected; // R20

  // valid-bit count of the payload sent in this fifo frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifoBits_r <= scp_pkg::RST_BYTE;
    end else if (byteDone && (state_r == scp_pkg::ST_CMD)) begin
      // the word popped by the instruction itself is the first one counted
      fifoBits_r <= fifoPop ? scp_pkg::BITS_PER_WORD : scp_pkg::RST_BYTE; // R11
    end else if (fifoPop) begin
      fifoBits_r <= fifoBits_r + scp_pkg::BITS_PER_WORD; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write side: storage, traces, checksum

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrTrace_r <= scp_pkg::RST_BYTE;
      dataTrace_r <= scp_pkg::RST_BYTE;
    end else if (wrStrobe) begin
      addrTrace_r <= addr_r; // R4 R5 R7
      dataTrace_r <= rxByte; // R4 R5 R7
    end
  end

  // fresh sum each write frame; a sum being read is cleared after the byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      checksum_r <= scp_pkg::RST_BYTE;
    end else if (byteDone && (state_r == scp_pkg::ST_ADDR) && isWrite_r) begin
      checksum_r <= rxByte; // R8 R10
    end else if (wrStrobe) begin
      checksum_r <= checksum_r ^ rxByte; // R8 R10
    end else if (chkClear) begin
      checksum_r <= scp_pkg::RST_BYTE; // R9
    end
  end

  // storage has no reset: it is a plain array, cleared only by writes
  always_ff @(posedge clk) begin
    if (wrStrobe && (addr_r >= scp_pkg::ADDR_CFG_BASE)) begin
      cfgMem[addr_r] <= rxByte; // R3 R6
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgWrValid <= 1'b0;
      cfgWr      <= '0;
    end else begin
      cfgWrValid <= wrStrobe && (addr_r >= scp_pkg::ADDR_CFG_BASE);
      if (wrStrobe) begin
        cfgWr <= '{addr: addr_r, data: rxByte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clear-on-read: events between capture and byte end are lost by design

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clearIsPend_r  <= 1'b0;
      irqStatusClear <= 1'b0;
    end else begin
      irqStatusClear <= 1'b0;
      if (!selected) begin
        clearIsPend_r <= 1'b0; // R2 R20
      end else if (byteDone) begin
        if (state_r == scp_pkg::ST_READ && clearIsPend_r) begin
          irqStatusClear <= 1'b1; // R18
        end
        if ((state_r == scp_pkg::ST_ADDR) && !isWrite_r) begin
          clearIsPend_r <= (rxByte == scp_pkg::ADDR_IRQ_STATUS); // R18
        end else if ((state_r == scp_pkg::ST_READ) && burst_r) begin
          clearIsPend_r <= (nextAddr == scp_pkg::ADDR_IRQ_STATUS); // R18
        end else begin
          clearIsPend_r <= 1'b0;
        end
      end
    end
  end

  scp_fifo #(
    .WIDTH (scp_pkg::FIFO_WIDTH),
    .DEPTH (scp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (rxWordValid),
    .inReady  (rxWordReady),
    .inData   (rxWordData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_write_byte;
    wrStrobe && burst_r;
  endsequence

  property p_release;
    !selected && $past(!selected) |-> !spiDataOutEn && $stable(spiDataOut);
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected"); // R20

  property p_abort;
    csRise |=> (state_r == scp_pkg::ST_CMD) && (bitCnt_r == 3'h0);
  endproperty
  a_abort: assert property (p_abort) else $error("frame not aborted on deselect"); // R20

  property p_trace;
    wrStrobe |=> (addrTrace_r == $past(addr_r)) && (dataTrace_r == $past(rxByte));
  endproperty
  a_trace: assert property (p_trace) else $error("trace not updated on write"); // R4

  property p_burst_inc;
    s_write_byte |=> addr_r == $past(nextAddr);
  endproperty
  a_burst_inc: assert property (p_burst_inc) else $error("burst address not advanced"); // R6

  property p_checksum;
    wrStrobe |=> checksum_r == ($past(checksum_r) ^ $past(rxByte));
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum fold wrong"); // R8

  property p_chk_clear;
    chkClear |=> checksum_r == 8'h00;
  endproperty
  a_chk_clear: assert property (p_chk_clear) else $error("checksum not cleared on read"); // R9

  property p_single_ends;
    wrStrobe && !burst_r |=> state_r == scp_pkg::ST_CMD;
  endproperty
  a_single_ends: assert property (p_single_ends) else $error("single write not closed"); // R17

  property p_is_clear;
    irqStatusClear |-> $past(state_r) == scp_pkg::ST_READ && $past(byteDone);
  endproperty
  a_is_clear: assert property (p_is_clear) else $error("status cleared out of place"); // R18

  property p_cfg_pulse;
    cfgWrValid |=> !cfgWrValid || $past(wrStrobe);
  endproperty
  a_cfg_pulse: assert property (p_cfg_pulse) else $error("config strobe stuck"); // R3

endmodule

/* verif/scp_master_model.sv */
// Purpose: serial master on the far side of the control port
// Assumes: mode 0, link clock 200 ns, paced by the system clock
// Notes:   link clock stands still low between frames
`timescale 1ns/1ps
module scp_master_model (
  // pacing clock
  input  wire logic clk,
  // serial pins
  output logic      spiClk,
  output logic      chip_select_n,
  output logic      spiDataIn,
  input  wire logic spiDataOut
);
  // half of the 200 ns link period in 25 ns cycles
  localparam int HALF = 4;

  initial begin
    spiClk        = 1'b0;
    chip_select_n = 1'b1;
    spiDataIn     = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic select_dev();
    @(negedge clk);
    chip_select_n = 1'b0;
    wait_clk(HALF);
  endtask

  // released data line flips so a held value is never mistaken for data
  task automatic deselect_dev();
    wait_clk(HALF);
    chip_select_n = 1'b1;
    spiDataIn     = ~spiDataIn;
    wait_clk(6);
  endtask

  // bursts are never stopped just below the clear-on-read place
  task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nBits; i--) begin
      spiDataIn = tx[i];
      wait_clk(HALF);
      spiClk = 1'b1;
      wait_clk(1);
      rx = {rx[6:0], spiDataOut};
      wait_clk(HALF - 1);
      spiClk = 1'b0;
    end
  endtask
endmodule

/* verif/scp_testbench.sv */
// Purpose: self-checking bench of the serial control port
// Assumes: 40 MHz clock, master model paces the link
// Notes:   the bench stands in for the receiver and status source
`timescale 1ns/1ps
module testbench;
  localparam int TIMEOUT = 20000;

  logic                 clk;
  logic                 sys_rst;
  logic                 spiClk;
  logic                 chip_select_n;
  logic                 spiDataIn;
  logic                 spiDataOut;
  logic                 spiDataOutEn;
  logic                 rxWordValid;
  logic                 rxWordReady;
  logic [7:0]           rxWordData;
  logic [7:0]           irqStatus;
  logic                 irqStatusClear;
  logic                 cfgWrValid;
  scp_pkg::scp_cfg_wr_t cfgWr;
  scp_pkg::scp_cfg_wr_t lastCfg;
  int                   errCount;
  int                   compares;
  int                   cycles;
  int                   cfgPulses;
  int                   clrPulses;
  logic [7:0]           rd;
  logic                 sdoLine;

  // released line shows the inverse so a stale bit is never taken as data
  assign sdoLine = spiDataOutEn ? spiDataOut : ~spiDataOut;

  scp_spi_slave scp_spi_slave_inst (
    .clk(clk), .sys_rst(sys_rst), .spiClk(spiClk), .chip_select_n(chip_select_n),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn),
    .rxWordValid(rxWordValid), .rxWordReady(rxWordReady), .rxWordData(rxWordData),
    .irqStatus(irqStatus), .irqStatusClear(irqStatusClear),
    .cfgWrValid(cfgWrValid), .cfgWr(cfgWr)
  );

  scp_master_model scp_master_model_inst (
    .clk(clk), .spiClk(spiClk), .chip_select_n(chip_select_n),
    .spiDataIn(spiDataIn), .spiDataOut(sdoLine)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cfgWrValid === 1'b1) begin
      cfgPulses++;
      lastCfg = cfgWr;
    end
    if (irqStatusClear === 1'b1) begin
      clrPulses++;
    end
    cycles++;
    if (cycles >= TIMEOUT) begin
      errCount++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction

  task automatic put(input logic [7:0] b);
    logic [7:0] dummy;
    scp_master_model_inst.xfer(b, 8, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] v;
    put(scp_pkg::CMD_READ);
    put(a);
    scp_master_model_inst.xfer(8'h00, 8, v);
    check({8'h00, v}, {8'h00, exp}, msg);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(spiDataOutEn, 1'b0, "enable after reset");
    check(rxWordReady, 1'b1, "ready after reset");
    check(cfgWr, 16'h0000, "cfg after reset");
  endtask

  task automatic test_write();
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_WRITE);
    put(8'h10);
    put(8'ha5);
    check(spiDataOutEn, 1'b1, "enable while selected");
    rd_chk(scp_pkg::ADDR_ADDRESS_TRACE, 8'h10, "address trace");
    rd_chk(scp_pkg::ADDR_DATA_TRACE, 8'ha5, "data trace");
    rd_chk(scp_pkg::ADDR_CHECKSUM, 8'h10 ^ 8'ha5, "checksum");
    rd_chk(scp_pkg::ADDR_CHECKSUM, 8'h00, "checksum cleared");
    rd_chk(8'h10, 8'ha5, "stored byte");
    scp_master_model_inst.deselect_dev();
    check(spiDataOutEn, 1'b0, "enable released");
    check(cfgPulses, 1, "single write pulses");
    check(lastCfg, {8'h10, 8'ha5}, "single write value");
  endtask

  task automatic test_burst();
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_BURST_WRITE);
    put(8'h20);
    put(8'h11);
    put(8'h22);
    put(8'h33);
    scp_master_model_inst.deselect_dev();
    check(cfgPulses, 4, "burst write pulses");
    check(lastCfg, {8'h22, 8'h33}, "burst last value");
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_BURST_READ);
    put(8'h20);
    for (int k = 0; k < 3; k++) begin
      scp_master_model_inst.xfer(8'h00, 8, rd);
      check(rd, 8'h11 * (k + 1), "burst read byte");
    end
    scp_master_model_inst.deselect_dev();
    scp_master_model_inst.select_dev();
    rd_chk(scp_pkg::ADDR_ADDRESS_TRACE, 8'h22, "burst address trace");
    rd_chk(scp_pkg::ADDR_DATA_TRACE, 8'h33, "burst data trace");
    rd_chk(scp_pkg::ADDR_CHECKSUM, 8'h20 ^ 8'h11 ^ 8'h22 ^ 8'h33, "burst checksum");
    scp_master_model_inst.deselect_dev();
  endtask

  task automatic test_serial();
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_BURST_READ);
    put(scp_pkg::ADDR_SERIAL_BYTE0);
    for (int k = 0; k < 4; k++) begin
      scp_master_model_inst.xfer(8'h00, 8, rd);
      check(rd, scp_pkg::SERIAL_NUMBER[8 * k +: 8], "serial byte");
    end
    scp_master_model_inst.deselect_dev();
  endtask

  task automatic test_status();
    @(negedge clk);
    irqStatus = 8'h5c;
    scp_master_model_inst.select_dev();
    rd_chk(scp_pkg::ADDR_IRQ_STATUS, 8'h5c, "status read");
    scp_master_model_inst.deselect_dev();
    check(clrPulses, 1, "status clear pulse");
    // deselect in mid data byte must drop the pending clear
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_READ);
    put(scp_pkg::ADDR_IRQ_STATUS);
    scp_master_model_inst.xfer(8'h00, 4, rd);
    scp_master_model_inst.deselect_dev();
    check(clrPulses, 1, "aborted status read");
  endtask

  task automatic test_unknown();
    scp_master_model_inst.select_dev();
    put(8'h07);
    scp_master_model_inst.xfer(scp_pkg::CMD_WRITE, 8, rd);
    check(rd, 8'h00, "ignored frame output");
    put(8'h10);
    put(8'hee);
    scp_master_model_inst.deselect_dev();
    check(cfgPulses, 4, "ignored frame no write");
    scp_master_model_inst.select_dev();
    rd_chk(8'h10, 8'ha5, "stored byte kept");
    scp_master_model_inst.deselect_dev();
  endtask

  task automatic test_fifo();
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      rxWordValid = 1'b1;
      rxWordData  = 8'h10 + 8'(k);
    end
    @(negedge clk);
    rxWordData = 8'hff;
    check(rxWordReady, 1'b0, "fifo full refuses");
    repeat (3) @(negedge clk);
    check(rxWordReady, 1'b0, "fifo stays full");
    rxWordValid = 1'b0;
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_FIFO_READ);
    for (int k = 0; k < 16; k++) begin
      scp_master_model_inst.xfer(8'h00, 8, rd);
      check(rd, rev8(8'h10 + 8'(k)), "fifo word");
    end
    scp_master_model_inst.xfer(8'h00, 8, rd);
    check(rd, 8'h80, "fifo bit count");
    scp_master_model_inst.deselect_dev();
    check(rxWordReady, 1'b1, "fifo drained");
    scp_master_model_inst.select_dev();
    put(scp_pkg::CMD_FIFO_READ);
    scp_master_model_inst.xfer(8'h00, 8, rd);
    check(rd, 8'h00, "empty fifo count");
    scp_master_model_inst.deselect_dev();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    errCount    = 0;
    compares    = 0;
    cycles      = 0;
    cfgPulses   = 0;
    clrPulses   = 0;
    lastCfg     = 16'h0000;
    sys_rst     = 1'b1;
    rxWordValid = 1'b0;
    rxWordData  = 8'h00;
    irqStatus   = 8'h00;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    test_reset();
    test_write();
    test_burst();
    test_serial();
    test_status();
    test_unknown();
    test_fifo();
    complete_run();
  end
endmodule
